// [hdl/scl_pkg.sv]
package scl_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_STATUS  = 16'h4011;
  localparam logic [15:0] IDX_MASK    = 16'h4019;
  localparam logic [15:0] IDX_KEY     = 16'h4007;
  localparam logic [15:0] IDX_TAG     = 16'h4020;
  localparam logic [15:0] IDX_TIME_HI = 16'h4021;
  localparam logic [15:0] IDX_TIME_LO = 16'h4022;
  localparam logic [15:0] IDX_ALM_HI  = 16'h4023;
  localparam logic [15:0] IDX_ALM_LO  = 16'h4024;
  localparam logic [15:0] IDX_CTRL    = 16'h4025;
  localparam logic [15:0] IDX_TRIM    = 16'h4026;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          BIT_ALM_EV   = 2;
  localparam int          BIT_PER_EV   = 3;
  localparam int          BIT_VALID    = 15;
  localparam int          BIT_BUSY     = 14;
  localparam int          BIT_ALM_EN   = 10;
  localparam int          PER_LSB      = 4;
  localparam int          TRIM_W       = 10;
  localparam logic [1:0]  MASK_RST     = 2'h3;
  localparam logic [15:0] TAG_RST      = 16'h0000;
  localparam logic [31:0] TIME_RST     = 32'h0000_0000;
  localparam logic [31:0] ALM_RST      = 32'h0000_0000;
  localparam logic [15:0] LFSR_SEED    = 16'hace1;
  // Unlock code value is arbitrary.
  localparam logic [15:0] KEY_UNLOCK   = 16'h5a3c;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          CLK_HZ       = 250_000_000;
  localparam int          OSC_HZ       = 32_768;
  localparam int          OSC_DIV      = CLK_HZ / OSC_HZ;
  localparam int          FRAC_BITS    = 6;
  localparam int          ACC_W        = 22;
  localparam int          HOUR_S       = 3600;
  localparam int          WR_LIMIT     = 8;
  localparam logic [2:0]  SYNC_CYC     = 3'h3;

  typedef struct packed {
    logic       alm_en;
    logic [2:0] period;
  } scl_ctrl_t;

endpackage

// [hdl/scl_rtc.sv]
`timescale 1ns/10ps
`default_nettype none
// Operation
// RULE1 - 32-bit seconds counter from 32.768 kHz oscillator, plus one each second.
// RULE2 - Counter always runs, no disable, including backup state.
// RULE3 - Counter readable and writable as halves at 4021h (high) and 4022h (low).
// RULE4 - Both counter halves start at zero after power-up.
// RULE5 - Time-set flag, control bit 15, sets after any counter write.
// RULE6 - Busy flag, control bit 14, high while an update synchronises.
// RULE7 - Software waits for busy low before writing counter or alarm.
// RULE8 - Write tag takes a new random value on each counter write; resets zero.
// RULE9 - At most eight counter updates per hour; extra writes silently dropped.
// RULE10 - Alarm value in halves at 4023h (high) and 4024h (low), reset zero.
// RULE11 - Alarm fires when enable bit 10 set and counter equals alarm.
// RULE12 - Alarm in sleep requests wake; alarm in off requests on.
// RULE13 - Software should disable the alarm while changing its value.
// RULE14 - Trim is 10-bit two's complement <4,6>, top bit weighs -8 Hz.
// RULE15 - Software programs trim with oscillator error; tick compensates it.
// RULE16 - Trim writes ignored unless unlock code written to key register first.
// RULE17 - Alarm event flag, bit 2 of 4011h, sets on rise, write-one clears.
// RULE18 - Mask bits 2 and 3 of 4019h reset to one; zero lets event interrupt.
// RULE19 - Period field bits 6:4: 000 off, else 2 s doubling to 128 s.
// RULE20 - Accepted counter writes tracked in a rolling one-hour window.
// RULE21 - Second tick from oscillator accumulation against trimmed terminal count.
module scl_rtc
  import scl_pkg::*;
#(
  parameter int OSC_DIV_P = OSC_DIV
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power sequencer
  input  wire logic        pwr_sleep,
  input  wire logic        pwr_off,
  output logic             wake_req,
  output logic             on_req,
  // Primary clock interrupt
  output logic             clock_irq
);

  function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
    return a == {idx, 2'b00};
  endfunction

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic        acc_en;
  logic        wr_en;
  logic        mapped;
  logic [15:0] wd;
  assign acc_en  = psel && penable;
  assign wr_en   = acc_en && pwrite;
  assign wd      = pwdata[15:0];
  assign pready  = 1'b1;
  assign mapped  = hit(paddr, IDX_STATUS) || hit(paddr, IDX_MASK) || hit(paddr, IDX_KEY)
                || hit(paddr, IDX_TAG) || hit(paddr, IDX_TIME_HI) || hit(paddr, IDX_TIME_LO)
                || hit(paddr, IDX_ALM_HI) || hit(paddr, IDX_ALM_LO) || hit(paddr, IDX_CTRL)
                || hit(paddr, IDX_TRIM);
  assign pslverr = acc_en && !mapped;

  logic wr_thi;
  logic wr_tlo;
  logic wr_time;
  logic wr_time_acc;
  logic wr_alm;
  logic wr_trim;
  assign wr_thi  = wr_en && hit(paddr, IDX_TIME_HI);
  assign wr_tlo  = wr_en && hit(paddr, IDX_TIME_LO);
  assign wr_time = wr_thi || wr_tlo;
  assign wr_alm  = wr_en && (hit(paddr, IDX_ALM_HI) || hit(paddr, IDX_ALM_LO));
  assign wr_trim = wr_en && hit(paddr, IDX_TRIM);

  // ---------------------------------------------------------------
  // Oscillator enable and trimmed second tick
  // ---------------------------------------------------------------
  logic [12:0]             div_r;
  logic                    osc_tick;
  logic [ACC_W-1:0]        acc_r;
  logic [ACC_W-1:0]        acc_sum;
  logic [ACC_W-1:0]        term;
  logic [TRIM_W-1:0]       trim_r;
  logic                    sec_tick;

  assign osc_tick = (div_r == 13'(OSC_DIV_P - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else if (osc_tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 13'h1;
    end
  end

  // The trim is in 1/64 Hz, so the terminal count is scaled by 64 and the
  // fractional part of the correction is spread over successive seconds.
  assign term     = ACC_W'(OSC_HZ << FRAC_BITS) + {{(ACC_W-TRIM_W){trim_r[TRIM_W-1]}}, trim_r}; // RULE14 RULE21
  assign acc_sum  = acc_r + ACC_W'(1 << FRAC_BITS);
  assign sec_tick = osc_tick && (acc_sum >= term);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
    end else if (osc_tick) begin
      acc_r <= sec_tick ? acc_sum - term : acc_sum; // RULE21
    end
  end

  // ---------------------------------------------------------------
  // Hourly write limit
  // ---------------------------------------------------------------
  logic [11:0] win_r [WR_LIMIT];
  logic [WR_LIMIT-1:0] slot_free;
  logic [WR_LIMIT-1:0] slot_take;

  genvar g;
  generate
    for (g = 0; g < WR_LIMIT; g++) begin : g_win
      assign slot_free[g] = (win_r[g] == 12'h0);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          win_r[g] <= 12'h0;
        end else if (slot_take[g]) begin
          win_r[g] <= 12'(HOUR_S); // RULE20
        end else if (sec_tick && !slot_free[g]) begin
          win_r[g] <= win_r[g] - 12'h1;
        end
      end
    end
  endgenerate

  // Lowest free slot takes the write; none free means the write is dropped.
  assign slot_take   = wr_time ? (slot_free & (~slot_free + WR_LIMIT'(1))) : '0;
  assign wr_time_acc = wr_time && (slot_free != '0); // RULE9

  // ---------------------------------------------------------------
  // Seconds counter, alarm value, tag
  // ---------------------------------------------------------------
  logic [31:0] cnt_r;
  logic [31:0] alm_r;
  logic [15:0] tag_r;
  logic [15:0] lfsr_r;
  logic        valid_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= TIME_RST; // RULE4
    end else if (wr_time_acc && wr_thi) begin
      cnt_r <= {wd, cnt_r[15:0]}; // RULE3
    end else if (wr_time_acc) begin
      cnt_r <= {cnt_r[31:16], wd};
    end else if (sec_tick) begin
      cnt_r <= cnt_r + 32'h1; // RULE1 RULE2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alm_r <= ALM_RST;
    end else if (wr_en && hit(paddr, IDX_ALM_HI)) begin
      alm_r <= {wd, alm_r[15:0]}; // RULE10
    end else if (wr_en && hit(paddr, IDX_ALM_LO)) begin
      alm_r <= {alm_r[31:16], wd};
    end
  end

  // Free-running generator makes the tag unpredictable from software timing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r <= LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_r <= TAG_RST;
    end else if (wr_time_acc) begin
      tag_r <= lfsr_r; // RULE8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_r <= 1'b0;
    end else if (wr_time_acc) begin
      valid_r <= 1'b1; // RULE5
    end
  end

  // ---------------------------------------------------------------
  // Synchronisation busy
  // ---------------------------------------------------------------
  logic [2:0] busy_r;
  logic       busy;
  logic       wr_sync;
  assign wr_sync = wr_time_acc || wr_alm;
  assign busy    = (busy_r != 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 3'h0;
    end else if (wr_sync) begin
      busy_r <= SYNC_CYC; // RULE6
    end else if (busy) begin
      busy_r <= busy_r - 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Control, trim and key
  // ---------------------------------------------------------------
  scl_ctrl_t ctrl_r;
  logic      unlock_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
    end else if (wr_en && hit(paddr, IDX_CTRL)) begin
      ctrl_r.alm_en <= wd[BIT_ALM_EN];
      ctrl_r.period <= wd[PER_LSB+2:PER_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_r <= 1'b0;
    end else if (wr_en && hit(paddr, IDX_KEY)) begin
      unlock_r <= (wd == KEY_UNLOCK);
    end else if (wr_trim) begin
      unlock_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_r <= '0;
    end else if (wr_trim && unlock_r) begin
      trim_r <= wd[TRIM_W-1:0]; // RULE16
    end
  end

  // ---------------------------------------------------------------
  // Alarm, periodic events, flags
  // ---------------------------------------------------------------
  logic        alm_hit;
  logic        alm_hit_r;
  logic        alm_rise;
  logic        per_hit;
  logic [31:0] per_mask;
  logic [1:0]  flag_r;
  logic [1:0]  mask_r;
  logic [1:0]  ev_set;
  logic [1:0]  ev_clr;

  assign alm_hit  = ctrl_r.alm_en && (cnt_r == alm_r); // RULE11
  assign alm_rise = alm_hit && !alm_hit_r;
  assign per_mask = (32'h1 << ctrl_r.period) - 32'h1;
  assign per_hit  = sec_tick && (ctrl_r.period != 3'h0) && (((cnt_r + 32'h1) & per_mask) == '0); // RULE19

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alm_hit_r <= 1'b0;
    end else begin
      alm_hit_r <= alm_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req <= 1'b0;
      on_req   <= 1'b0;
    end else begin
      wake_req <= alm_rise && pwr_sleep; // RULE12
      on_req   <= alm_rise && pwr_off;
    end
  end

  assign ev_set = {per_hit, alm_rise};
  assign ev_clr = (wr_en && hit(paddr, IDX_STATUS)) ? {wd[BIT_PER_EV], wd[BIT_ALM_EV]} : 2'h0;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 2'h0;
    end else begin
      flag_r <= (flag_r & ~ev_clr) | ev_set; // RULE17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= MASK_RST; // RULE18
    end else if (wr_en && hit(paddr, IDX_MASK)) begin
      mask_r <= {wd[BIT_PER_EV], wd[BIT_ALM_EV]};
    end
  end

  assign clock_irq = |(flag_r & ~mask_r); // RULE18

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    prdata = 32'h0;
    if (hit(paddr, IDX_STATUS) || hit(paddr, IDX_MASK)) begin
      prdata[BIT_ALM_EV] = hit(paddr, IDX_STATUS) ? flag_r[0] : mask_r[0];
      prdata[BIT_PER_EV] = hit(paddr, IDX_STATUS) ? flag_r[1] : mask_r[1];
    end else if (hit(paddr, IDX_TAG)) begin
      prdata[15:0] = tag_r;
    end else if (hit(paddr, IDX_TIME_HI)) begin
      prdata[15:0] = cnt_r[31:16];
    end else if (hit(paddr, IDX_TIME_LO)) begin
      prdata[15:0] = cnt_r[15:0];
    end else if (hit(paddr, IDX_ALM_HI)) begin
      prdata[15:0] = alm_r[31:16];
    end else if (hit(paddr, IDX_ALM_LO)) begin
      prdata[15:0] = alm_r[15:0];
    end else if (hit(paddr, IDX_CTRL)) begin
      prdata[BIT_VALID]              = valid_r;
      prdata[BIT_BUSY]               = busy;
      prdata[BIT_ALM_EN]             = ctrl_r.alm_en;
      prdata[PER_LSB+2:PER_LSB]      = ctrl_r.period;
    end else if (hit(paddr, IDX_TRIM)) begin
      prdata[TRIM_W-1:0] = trim_r;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_tick_step: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    sec_tick && !wr_time_acc |=> cnt_r == $past(cnt_r) + 32'h1) else $error("counter missed a second");
  a_valid_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    wr_time_acc |=> valid_r [*3]) else $error("time-set flag not held");
  a_busy_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    wr_sync ##1 !wr_sync [*4] |-> $past(busy, 3) && !busy) else $error("busy length wrong");
  a_tag_new: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    wr_time_acc |=> tag_r == $past(lfsr_r)) else $error("tag not refreshed");
  a_limit_drop: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    wr_time && slot_free == '0 |=> $stable(tag_r) && cnt_r != $past(wd)) else $error("over-limit write taken");
  a_alarm_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    !ctrl_r.alm_en |-> !alm_rise) else $error("alarm while disabled");
  a_alarm_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    alm_rise |=> flag_r[0]) else $error("alarm flag not set");
  a_wake_req: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    alm_rise && pwr_sleep |=> wake_req ##1 !wake_req) else $error("wake request wrong");
  a_trim_lock: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    wr_trim && !unlock_r |=> $stable(trim_r)) else $error("locked trim changed");
  a_period_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
    ctrl_r.period == 3'h0 |=> !flag_r[1] || $past(flag_r[1])) else $error("periodic event while off");

endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import scl_pkg::*;

  // ---------------------------------------------------------------
  // Design hookup
  // ---------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pwr_sleep, pwr_off;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, wake_req, on_req, clock_irq;
  int          fails, num_checks, wake_n, on_n, cyc;

  // A divide of two keeps one second at 65536 clocks, so one tick fits in the run.
  scl_rtc #(.OSC_DIV_P(2)) scl_rtc_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwr_sleep(pwr_sleep), .pwr_off(pwr_off), .wake_req(wake_req), .on_req(on_req),
    .clock_irq(clock_irq)
  );

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 18'h0; pwdata = 32'h0; pwr_sleep = 1'b0; pwr_off = 1'b0;
    fails = 0; num_checks = 0; wake_n = 0; on_n = 0; cyc = 0;
  end
  always #2 pclk = ~pclk;

  // Request pulses last one cycle, so they are counted rather than polled.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wake_req === 1'b1) wake_n <= wake_n + 1;
    if (on_req === 1'b1) on_n <= on_n + 1;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_ne(input logic [31:0] got, input logic [31:0] bad);
    num_checks++;
    if (got === bad) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=not %h", $time, got, bad);
    end
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic apb(input logic [15:0] idx, input logic wr, input logic [15:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {16'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
    logic [31:0] rd;
    logic        er;
    apb(idx, 1'b1, wd, rd, er);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(idx, 1'b0, 16'h0, rd, er);
    chk(rd, exp);
  endtask

  task automatic wait_idle();
    logic [31:0] rd;
    logic        er;
    int          n;
    n = 0;
    do begin
      apb(IDX_CTRL, 1'b0, 16'h0, rd, er);
      n++;
    end while (rd[BIT_BUSY] !== 1'b0 && n < 20);
    chk({31'h0, rd[BIT_BUSY]}, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_vals();
    logic [31:0] rd;
    logic        er;
    rd_chk(IDX_TAG, 32'h0);
    rd_chk(IDX_TIME_HI, 32'h0);
    rd_chk(IDX_TIME_LO, 32'h0);
    rd_chk(IDX_ALM_HI, 32'h0);
    rd_chk(IDX_ALM_LO, 32'h0);
    rd_chk(IDX_CTRL, 32'h0);
    rd_chk(IDX_MASK, 32'hc);
    rd_chk(IDX_STATUS, 32'h0);
    apb(16'h4027, 1'b0, 16'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("reset values test done");
  endtask

  task automatic t_time_limit();
    logic [31:0] rd, pv;
    logic        er;
    logic [15:0] idx;
    pv = 32'h0;
    for (int i = 0; i < WR_LIMIT; i++) begin
      idx = (i == 0) ? IDX_TIME_HI : IDX_TIME_LO;
      wr(idx, 16'h0100 + 16'(i));
      if (i == 0) begin
        apb(IDX_CTRL, 1'b0, 16'h0, rd, er);
        chk(rd & 32'hc000, 32'hc000);
      end
      wait_idle();
      rd_chk(idx, 32'h0100 + 32'(i));
      apb(IDX_TAG, 1'b0, 16'h0, rd, er);
      chk_ne(rd, pv);
      chk_ne(rd, pv + 32'h1);
      pv = rd;
    end
    rd_chk(IDX_CTRL, 32'h8000);
    wr(IDX_TIME_LO, 16'h0bad);
    rd_chk(IDX_CTRL, 32'h8000);
    rd_chk(IDX_TIME_LO, 32'h0107);
    rd_chk(IDX_TAG, pv);
    rd_chk(IDX_TIME_HI, 32'h0100);
    $display("time write limit test done");
  endtask

  task automatic t_trim();
    wr(IDX_TRIM, 16'h03ff);
    rd_chk(IDX_TRIM, 32'h0);
    wr(IDX_KEY, KEY_UNLOCK);
    wr(IDX_TRIM, 16'hffff);
    rd_chk(IDX_TRIM, 32'h03ff);
    wr(IDX_TRIM, 16'h0040);
    rd_chk(IDX_TRIM, 32'h03ff);
    $display("trim lock test done");
  endtask

  task automatic t_alarm();
    int w0, o0;
    pwr_sleep <= 1'b1;
    w0 = wake_n;
    o0 = on_n;
    wr(IDX_CTRL, 16'h0400);
    repeat (4) @(posedge pclk);
    chk(32'(wake_n - w0), 32'h1);
    chk(32'(on_n - o0), 32'h0);
    rd_chk(IDX_STATUS, 32'h4);
    chk({31'h0, clock_irq}, 32'h0);
    wr(IDX_MASK, 16'h0008);
    repeat (2) @(posedge pclk);
    chk({31'h0, clock_irq}, 32'h1);
    wr(IDX_STATUS, 16'h0004);
    repeat (2) @(posedge pclk);
    chk({31'h0, clock_irq}, 32'h0);
    rd_chk(IDX_STATUS, 32'h0);
    wr(IDX_CTRL, 16'h0000);
    pwr_sleep <= 1'b0;
    pwr_off <= 1'b1;
    wr(IDX_CTRL, 16'h0400);
    repeat (4) @(posedge pclk);
    chk(32'(on_n - o0), 32'h1);
    chk(32'(wake_n - w0), 32'h1);
    wr(IDX_CTRL, 16'h0000);
    wr(IDX_ALM_LO, 16'h0005);
    wait_idle();
    rd_chk(IDX_ALM_LO, 32'h5);
    wr(IDX_CTRL, 16'h0400);
    wr(IDX_CTRL, 16'h0000);
    wr(IDX_ALM_LO, 16'h0000);
    wait_idle();
    repeat (4) @(posedge pclk);
    chk(32'(on_n - o0), 32'h1);
    pwr_off <= 1'b0;
    $display("alarm test done");
  endtask

  task automatic t_tick();
    logic [31:0] rd;
    logic        er;
    int          t0, n;
    do_reset();
    t0 = cyc;
    n = 0;
    wr(IDX_CTRL, 16'h0010);
    wr(IDX_TIME_LO, 16'h0001);
    do begin
      apb(IDX_TIME_LO, 1'b0, 16'h0, rd, er);
      n++;
    end while (rd === 32'h1 && n < 30000);
    chk(rd, 32'h2);
    chk({31'h0, (cyc - t0 > 65500) && (cyc - t0 < 65620)}, 32'h1);
    rd_chk(IDX_STATUS, 32'h8);
    $display("second tick test done");
  endtask

  // ---------------------------------------------------------------
  // Sequence and verdict
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    t_reset_vals();
    t_time_limit();
    t_trim();
    do_reset();
    t_alarm();
    t_tick();
    final_report();
  end

  initial begin
    #400000;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
